// File: shared/bbc_regs.vh
// Constants for the bus break comparator
// Behaviour
// [RULE1] 16-bit longword: word data, even address
// [RULE2] 16-bit word: one cycle, even address
// [RULE3] 16-bit byte: byte data, any address
// [RULE4] Byte data without exact address hits even
// [RULE5] 8-bit area: bytes, any address allowed
// [RULE6] 8-bit area: only byte data valid
// [RULE7] Address masks per bit, masked bits match
// [RULE8] Single address mask contiguous from bit 0
// [RULE9] Data, irq, probe masks are arbitrary
// [RULE10] Stop request may land several instructions late
// [RULE11] Eight channels; cancel without number clears group
// [RULE12] Channel claimed by trace refuses break setting
// [RULE13] Byte data wants exact unmasked address
// [RULE14] Four on-chip channels halt on match
// [RULE15] On-chip channels chain up to four levels
// [RULE16] One access type, or none for all
// [RULE17] Group B hit counter 1 to 65535
// [RULE18] All enabled qualifiers true same cycle
`ifndef BBC_REGS_VH
`define BBC_REGS_VH
`define BBC_NCH 28
`define BBC_GRP_B 2'h1
`define BBC_GRP_OCB 2'h3
`define BBC_CNT_CH_B_LO 5'h08
`define BBC_CNT_CH_B_HI 5'h0F
`define BBC_CNT_CH_OCB 5'h18
// Programming field selectors
`define BBC_F_ADDR 3'h0
`define BBC_F_AMASK 3'h1
`define BBC_F_DATA 3'h2
`define BBC_F_DMASK 3'h3
`define BBC_F_CTRL 3'h4
`define BBC_F_PIN 3'h5
`define BBC_F_COUNT 3'h6
`define BBC_F_COMMIT 3'h7
// Control word bit positions
`define BBC_C_ADDR_EN 0
`define BBC_C_DATA_EN 1
`define BBC_C_DSIZE 3:2
`define BBC_C_RW_EN 4
`define BBC_C_RW_WR 5
`define BBC_C_TYPE 7:6
`define BBC_C_WIDTH 9:8
`define BBC_C_NMI_EN 10
`define BBC_C_NMI_HI 11
`define BBC_C_IRQ_EN 12
`define BBC_C_PRB_EN 13
`define BBC_C_NOT 14
`define BBC_C_CNT_EN 15
// Pin word layout: irq value, irq mask, probe value, probe mask
`define BBC_P_IRQ_V 7:0
`define BBC_P_IRQ_M 15:8
`define BBC_P_PRB_V 19:16
`define BBC_P_PRB_M 23:20
// Sizes, cycle types, area widths
`define BBC_SZ_BYTE 2'h0
`define BBC_SZ_WORD 2'h1
`define BBC_SZ_LONG 2'h2
`define BBC_TY_ANY 2'h0
`define BBC_TY_EXEC 2'h1
`define BBC_TY_DMA 2'h2
`define BBC_TY_BAD 2'h3
`define BBC_BT_FETCH 2'h0
`define BBC_W8 2'h0
`define BBC_W16 2'h1
`define BBC_W32 2'h2
`endif

// File: logic/bbc_chan.v
// One break channel: qualifier compare plus optional hit counter
`timescale 1ns/1ps
module bbc_chan #(
    parameter HAS_CNT = 0
) (
    input wire clk,
    input wire nrst,
    input wire clr,
    input wire valid,
    input wire [31:0] c_addr,
    input wire [31:0] c_amask,
    input wire [31:0] c_data,
    input wire [31:0] c_dmask,
    input wire [15:0] c_ctrl,
    input wire [23:0] c_pin,
    input wire [15:0] c_count,
    input wire bus_valid,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_data,
    input wire bus_rd,
    input wire [1:0] bus_size,
    input wire [1:0] bus_type,
    input wire [7:0] irq_s,
    input wire nmi_s,
    input wire [3:0] prb_s,
    output reg hit_q
);
`include "bbc_regs.vh"
    reg [15:0] cnt_q; // Matches seen so far
    reg [2:0] wbytes; // Area width in bytes
    reg [2:0] dbytes; // Data condition size in bytes
    reg [1:0] omask; // Address bits picking the lane
    reg [1:0] off; // Lane offset in bytes
    reg [4:0] sh; // Right shift to the lane
    reg [31:0] dm; // Active data bits
    reg [31:0] bval;
    reg exact, a_ok, d_ok, rw_ok, ty_ok, pin_ok, cond;

    // Combinational qualifier evaluation for one bus cycle
    always @* begin
        wbytes = (c_ctrl[`BBC_C_WIDTH] == `BBC_W8) ? 3'h1 : (c_ctrl[`BBC_C_WIDTH] == `BBC_W16) ? 3'h2 : 3'h4;
        dbytes = (c_ctrl[`BBC_C_DSIZE] == `BBC_SZ_BYTE) ? 3'h1 : (c_ctrl[`BBC_C_DSIZE] == `BBC_SZ_WORD) ? 3'h2 : 3'h4;
        dm = (dbytes == 3'h1) ? 32'h000000FF : (dbytes == 3'h2) ? 32'h0000FFFF : 32'hFFFFFFFF;
        omask = (wbytes[1:0] - 2'h1) & ~(dbytes[1:0] - 2'h1);
        // Masked bits always match [RULE7]
        a_ok = !c_ctrl[`BBC_C_ADDR_EN] || (((bus_addr ^ c_addr) & ~c_amask) == 32'h00000000);
        exact = c_ctrl[`BBC_C_ADDR_EN] && (c_amask == 32'h00000000);
        // Without an exact address the lowest lane is used, so hits land on aligned addresses [RULE4] [RULE13]
        off = exact ? (c_addr[1:0] & omask) : 2'h0;
        sh = {(wbytes[1:0] - dbytes[1:0] - off), 3'h0};
        bval = bus_data >> sh;
        // Size must equal the cycle size; 16-bit longwords arrive as two word cycles [RULE1] [RULE2] [RULE3] [RULE5]
        d_ok = !c_ctrl[`BBC_C_DATA_EN] || ((bus_type != `BBC_BT_FETCH) && (bus_size == c_ctrl[`BBC_C_DSIZE])
            && ((bus_addr[1:0] & omask) == off)
            && (((((bval ^ c_data) & ~c_dmask & dm) == 32'h00000000)) ^ c_ctrl[`BBC_C_NOT])); // [RULE9]
        rw_ok = !c_ctrl[`BBC_C_RW_EN] || (bus_rd != c_ctrl[`BBC_C_RW_WR]);
        // No type selected admits fetch cycles too [RULE16]
        ty_ok = (c_ctrl[`BBC_C_TYPE] == `BBC_TY_ANY)
            || ((c_ctrl[`BBC_C_TYPE] == `BBC_TY_EXEC) && (bus_type == `BBC_TY_EXEC))
            || ((c_ctrl[`BBC_C_TYPE] == `BBC_TY_DMA) && (bus_type == `BBC_TY_DMA));
        // Irq and probe levels compared with arbitrary masks, NMI level unmasked [RULE9]
        pin_ok = (!c_ctrl[`BBC_C_NMI_EN] || (nmi_s == c_ctrl[`BBC_C_NMI_HI]))
            && (!c_ctrl[`BBC_C_IRQ_EN] || (((irq_s ^ c_pin[`BBC_P_IRQ_V]) & ~c_pin[`BBC_P_IRQ_M]) == 8'h00))
            && (!c_ctrl[`BBC_C_PRB_EN] || (((prb_s ^ c_pin[`BBC_P_PRB_V]) & ~c_pin[`BBC_P_PRB_M]) == 4'h0));
        // Every enabled qualifier in the same cycle [RULE18]
        cond = valid && bus_valid && a_ok && d_ok && rw_ok && ty_ok && pin_ok;
    end

    // Hit pulse, optionally after the programmed number of matches
    always @(posedge clk) begin
        if (!nrst || clr) begin
            hit_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else if (cond && HAS_CNT != 0 && c_ctrl[`BBC_C_CNT_EN]) begin
            // Counter restarts after each completed run [RULE17]
            if (cnt_q + 16'h0001 == c_count) begin
                hit_q <= 1'b1;
                cnt_q <= 16'h0000;
            end else begin
                hit_q <= 1'b0;
                cnt_q <= cnt_q + 16'h0001;
            end
        end else begin
            hit_q <= cond;
        end
    end
endmodule

// File: logic/bbc_seq.v
// Level sequencer for the four on-chip break channels
`timescale 1ns/1ps
module bbc_seq (
    input wire clk,
    input wire nrst,
    input wire clr,
    input wire seq_en,
    input wire [1:0] seq_depth,
    input wire [3:0] hit,
    output reg brk_q,
    output reg [1:0] level_q
);
`include "bbc_regs.vh"
    // Chained mode waits on one level at a time
    always @(posedge clk) begin
        if (!nrst || clr) begin
            brk_q <= 1'b0;
            level_q <= 2'h0;
        end else if (!seq_en) begin
            // Independent channels: any hit halts [RULE14]
            brk_q <= |hit;
            level_q <= 2'h0;
        end else if (hit[level_q]) begin
            // Each level arms the next; last one breaks [RULE15]
            if (level_q == seq_depth) begin
                brk_q <= 1'b1;
                level_q <= 2'h0;
            end else begin
                brk_q <= 1'b0;
                level_q <= level_q + 2'h1;
            end
        end else begin
            brk_q <= 1'b0;
        end
    end
endmodule

// File: logic/bbc_top.v
// Bus break comparator top: channel setup, checks and stop request
`timescale 1ns/1ps
module bbc_top (
    input wire clk,
    input wire nrst,
    input wire cfg_we,
    input wire [4:0] cfg_chan,
    input wire [2:0] cfg_field,
    input wire [31:0] cfg_wdata,
    input wire cfg_cancel,
    input wire cfg_all,
    input wire [23:0] trace_claim,
    input wire seq_en,
    input wire [1:0] seq_depth,
    input wire bus_valid,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_data,
    input wire bus_rd,
    input wire [1:0] bus_size,
    input wire [1:0] bus_type,
    input wire [7:0] irq_pin,
    input wire nmi_pin,
    input wire [3:0] probe_pin,
    input wire stop_ack,
    output reg break_req,
    output reg [27:0] chan_hit,
    output reg [27:0] chan_valid,
    output reg [1:0] seq_level,
    output reg cfg_done,
    output reg cfg_refused
);
`include "bbc_regs.vh"
    // Per-channel settings
    reg [31:0] addr_q [0:27];
    reg [31:0] amask_q [0:27];
    reg [31:0] data_q [0:27];
    reg [31:0] dmask_q [0:27];
    reg [15:0] ctrl_q [0:27];
    reg [23:0] pin_q [0:27];
    reg [15:0] count_q [0:27];
    reg [27:0] clr_q; // Restart counters on commit or cancel
    // Pin synchronisers, first stage read only by second
    reg [7:0] irq_m_q, irq_s_q;
    reg nmi_m_q, nmi_s_q;
    reg [3:0] prb_m_q, prb_s_q;
    wire [27:0] hit_w; // Channel hit pulses
    wire ocb_brk_w; // On-chip unit break pulse
    wire [1:0] ocb_level_w;
    reg refuse; // Commit check result
    reg [27:0] cancel_set; // Channels to clear
    integer k;
    integer j; // Reset loop

    // Low run of ones only: no unmasked bit below a masked one
    function contig_mask;
        input [31:0] m;
        begin
            contig_mask = ((m & (m + 32'h00000001)) == 32'h00000000);
        end
    endfunction

    // Channel index to its group code
    function [1:0] grp_of;
        input [4:0] ch;
        begin
            grp_of = ch[4:3];
        end
    endfunction

    // Inputs from outside the clock domain pass two flops
    always @(posedge clk) begin
        if (!nrst) begin
            irq_m_q <= 8'h00;
            irq_s_q <= 8'h00;
            nmi_m_q <= 1'b0;
            nmi_s_q <= 1'b0;
            prb_m_q <= 4'h0;
            prb_s_q <= 4'h0;
        end else begin
            irq_m_q <= irq_pin;
            irq_s_q <= irq_m_q;
            nmi_m_q <= nmi_pin;
            nmi_s_q <= nmi_m_q;
            prb_m_q <= probe_pin;
            prb_s_q <= prb_m_q;
        end
    end

    // Validity checks applied when a channel is committed
    always @* begin
        refuse = 1'b0;
        if (cfg_chan > 5'h1B) begin
            refuse = 1'b1; // No such channel
        end else if (grp_of(cfg_chan) != `BBC_GRP_OCB && trace_claim[cfg_chan]) begin
            refuse = 1'b1; // Comparator held by trace or measurement [RULE12]
        end else if (ctrl_q[cfg_chan][`BBC_C_ADDR_EN] && !contig_mask(amask_q[cfg_chan])) begin
            refuse = 1'b1; // Holes in a single-address mask [RULE8]
        end else if (ctrl_q[cfg_chan][`BBC_C_TYPE] == `BBC_TY_BAD) begin
            refuse = 1'b1; // Two access types at once [RULE16]
        end else if (ctrl_q[cfg_chan][`BBC_C_WIDTH] == 2'h3) begin
            refuse = 1'b1; // Undefined area width
        end else if (ctrl_q[cfg_chan][`BBC_C_DATA_EN]
            && ctrl_q[cfg_chan][`BBC_C_WIDTH] == `BBC_W8
            && ctrl_q[cfg_chan][`BBC_C_DSIZE] != `BBC_SZ_BYTE) begin
            refuse = 1'b1; // Only byte data on an 8-bit area [RULE6] [RULE5]
        end else if (ctrl_q[cfg_chan][`BBC_C_DATA_EN]
            && ctrl_q[cfg_chan][`BBC_C_WIDTH] == `BBC_W16
            && ctrl_q[cfg_chan][`BBC_C_DSIZE] != `BBC_SZ_BYTE
            && ctrl_q[cfg_chan][`BBC_C_DSIZE] != `BBC_SZ_WORD) begin
            refuse = 1'b1; // Longword data refused on a 16-bit area [RULE1]
        end else if (ctrl_q[cfg_chan][`BBC_C_DATA_EN] && ctrl_q[cfg_chan][`BBC_C_ADDR_EN]
            && ctrl_q[cfg_chan][`BBC_C_DSIZE] == `BBC_SZ_WORD && addr_q[cfg_chan][0]) begin
            refuse = 1'b1; // Word data wants an even address [RULE2]
        end else if (ctrl_q[cfg_chan][`BBC_C_DATA_EN] && ctrl_q[cfg_chan][`BBC_C_ADDR_EN]
            && ctrl_q[cfg_chan][`BBC_C_DSIZE] == `BBC_SZ_LONG && addr_q[cfg_chan][1:0] != 2'h0) begin
            refuse = 1'b1; // Longword data wants a multiple of four
        end else if (ctrl_q[cfg_chan][`BBC_C_DSIZE] == 2'h3) begin
            refuse = 1'b1; // Undefined data size
        end else if (ctrl_q[cfg_chan][`BBC_C_NOT] && grp_of(cfg_chan) != `BBC_GRP_B) begin
            refuse = 1'b1; // Inverted data only in group B
        end else if (ctrl_q[cfg_chan][`BBC_C_CNT_EN]) begin
            // Counter only on group B and the first on-chip channel [RULE17]
            if (!((cfg_chan >= `BBC_CNT_CH_B_LO && cfg_chan <= `BBC_CNT_CH_B_HI) || cfg_chan == `BBC_CNT_CH_OCB)) begin
                refuse = 1'b1;
            end else if (count_q[cfg_chan] == 16'h0000) begin
                refuse = 1'b1;
            end
        end
    end

    // Channels cleared by a cancel request
    always @* begin
        cancel_set = 28'h0000000;
        for (k = 0; k < `BBC_NCH; k = k + 1) begin
            // Whole group when no number is given [RULE11]
            if (cfg_all) begin
                if (grp_of(k[4:0]) == grp_of(cfg_chan)) begin
                    cancel_set[k] = 1'b1;
                end
            end else if (k[4:0] == cfg_chan) begin
                cancel_set[k] = 1'b1;
            end
        end
    end

    // Setting storage and command handling
    always @(posedge clk) begin
        if (!nrst) begin
            for (j = 0; j < `BBC_NCH; j = j + 1) begin
                addr_q[j] <= 32'h00000000;
                amask_q[j] <= 32'h00000000;
                data_q[j] <= 32'h00000000;
                dmask_q[j] <= 32'h00000000;
                ctrl_q[j] <= 16'h0000;
                pin_q[j] <= 24'h000000;
                count_q[j] <= 16'h0000;
            end
            chan_valid <= 28'h0000000;
            clr_q <= 28'hFFFFFFF;
            cfg_done <= 1'b0;
            cfg_refused <= 1'b0;
        end else begin
            clr_q <= 28'h0000000;
            cfg_done <= 1'b0;
            cfg_refused <= 1'b0;
            if (cfg_cancel) begin
                // Cancel has priority over a write in the same cycle
                chan_valid <= chan_valid & ~cancel_set;
                clr_q <= cancel_set;
                cfg_done <= 1'b1;
            end else if (cfg_we && cfg_chan > 5'h1B) begin
                cfg_refused <= 1'b1;
            end else if (cfg_we && chan_valid[cfg_chan]) begin
                // Live channel must be cancelled before it is changed
                cfg_refused <= 1'b1;
            end else if (cfg_we) begin
                case (cfg_field)
                    `BBC_F_ADDR: addr_q[cfg_chan] <= cfg_wdata;
                    `BBC_F_AMASK: amask_q[cfg_chan] <= cfg_wdata;
                    `BBC_F_DATA: data_q[cfg_chan] <= cfg_wdata;
                    `BBC_F_DMASK: dmask_q[cfg_chan] <= cfg_wdata;
                    `BBC_F_CTRL: ctrl_q[cfg_chan] <= cfg_wdata[15:0];
                    `BBC_F_PIN: pin_q[cfg_chan] <= cfg_wdata[23:0];
                    `BBC_F_COUNT: count_q[cfg_chan] <= cfg_wdata[15:0];
                    default: begin
                        // Commit arms the channel if it passes the checks
                        if (!refuse) begin
                            chan_valid[cfg_chan] <= 1'b1;
                            clr_q[cfg_chan] <= 1'b1;
                        end
                    end
                endcase
                if (cfg_field == `BBC_F_COMMIT && refuse) begin
                    cfg_refused <= 1'b1;
                end else begin
                    cfg_done <= 1'b1;
                end
            end
        end
    end

    // Twenty-eight channel comparators
    genvar g;
    generate
        for (g = 0; g < `BBC_NCH; g = g + 1) begin : gch
            bbc_chan #(
                .HAS_CNT(((g >= `BBC_CNT_CH_B_LO && g <= `BBC_CNT_CH_B_HI) || g == `BBC_CNT_CH_OCB) ? 1 : 0)
            ) u_chan (
                .clk(clk),
                .nrst(nrst),
                .clr(clr_q[g]),
                .valid(chan_valid[g]),
                .c_addr(addr_q[g]),
                .c_amask(amask_q[g]),
                .c_data(data_q[g]),
                .c_dmask(dmask_q[g]),
                .c_ctrl(ctrl_q[g]),
                .c_pin(pin_q[g]),
                .c_count(count_q[g]),
                .bus_valid(bus_valid),
                .bus_addr(bus_addr),
                .bus_data(bus_data),
                .bus_rd(bus_rd),
                .bus_size(bus_size),
                .bus_type(bus_type),
                .irq_s(irq_s_q),
                .nmi_s(nmi_s_q),
                .prb_s(prb_s_q),
                .hit_q(hit_w[g])
            );
        end
    endgenerate

    // On-chip unit level chaining
    bbc_seq u_seq (
        .clk(clk),
        .nrst(nrst),
        .clr(|clr_q[27:24]),
        .seq_en(seq_en),
        .seq_depth(seq_depth),
        .hit(hit_w[27:24]),
        .brk_q(ocb_brk_w),
        .level_q(ocb_level_w)
    );

    // Stop request held until the core acknowledges; a new hit beats the ack
    always @(posedge clk) begin
        if (!nrst) begin
            break_req <= 1'b0;
            chan_hit <= 28'h0000000;
            seq_level <= 2'h0;
        end else begin
            chan_hit <= hit_w;
            seq_level <= ocb_level_w;
            // Core may run on a few instructions before halting [RULE10]
            if ((|hit_w[23:0]) || ocb_brk_w) begin
                break_req <= 1'b1; // [RULE14]
            end else if (stop_ack) begin
                break_req <= 1'b0;
            end
        end
    end
endmodule

// File: tb/bbc_checker.sv
// Concurrent checks on the break comparator top ports
`timescale 1ns/1ps
module bbc_checker (
    input logic clk,
    input logic nrst,
    input logic cfg_we,
    input logic cfg_cancel,
    input logic cfg_all,
    input logic [4:0] cfg_chan,
    input logic [2:0] cfg_field,
    input logic [23:0] trace_claim,
    input logic seq_en,
    input logic [1:0] seq_depth,
    input logic stop_ack,
    input logic break_req,
    input logic [27:0] chan_hit,
    input logic [27:0] chan_valid,
    input logic [1:0] seq_level,
    input logic cfg_done,
    input logic cfg_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Setup request and its one-cycle answer
    sequence s_req;
        cfg_we || cfg_cancel;
    endsequence
    sequence s_ans;
        cfg_done || cfg_refused;
    endsequence
    a_cfg_answer: assert property (s_req |=> s_ans)
        else $error("setup request not answered");
    a_no_spur: assert property (s_ans |-> $past(cfg_we || cfg_cancel))
        else $error("answer without request");
    a_trace_refuse: assert property (cfg_we && !cfg_cancel && cfg_field == 3'h7 &&
        cfg_chan < 5'h18 && trace_claim[cfg_chan] |=> cfg_refused)
        else $error("claimed channel accepted");
    a_chan_range: assert property (cfg_we && !cfg_cancel && cfg_chan > 5'h1B |=> cfg_refused)
        else $error("missing channel accepted");
    a_hit_break: assert property (|chan_hit[23:0] |-> break_req)
        else $error("group hit without stop request");
    a_break_hold: assert property (break_req && !stop_ack |=> break_req)
        else $error("stop request dropped early");
    a_break_clear: assert property (stop_ack |=> !break_req || |chan_hit || $past(|chan_hit[27:24]))
        else $error("stop request kept after ack");
    a_armed_hit: assert property ((chan_hit & ~($past(chan_valid) | $past(chan_valid, 2) |
        $past(chan_valid, 3))) == 28'h0)
        else $error("hit on unarmed channel");
    a_cancel_all: assert property (cfg_cancel && cfg_all && cfg_chan[4:3] == 2'h0 |->
        ##[1:2] chan_valid[7:0] == 8'h00)
        else $error("group cancel left channels armed");
    a_seq_level: assert property (seq_en && $stable(seq_depth) |-> seq_level <= seq_depth)
        else $error("level beyond chain depth");
endmodule
bind bbc_top bbc_checker u_chk (.clk, .nrst, .cfg_we, .cfg_cancel, .cfg_all, .cfg_chan, .cfg_field,
    .trace_claim, .seq_en, .seq_depth, .stop_ack, .break_req, .chan_hit, .chan_valid, .seq_level,
    .cfg_done, .cfg_refused);

// File: tb/bbc_bus_model.sv
// Monitored target bus model with a late stop acknowledge
`timescale 1ns/1ps
module bbc_bus_model (
    input logic clk,
    input logic break_req,
    output logic bus_valid = 1'b0,
    output logic [31:0] bus_addr = 32'h0,
    output logic [31:0] bus_data = 32'h0,
    output logic bus_rd = 1'b0,
    output logic [1:0] bus_size = 2'h0,
    output logic [1:0] bus_type = 2'h0,
    output logic stop_ack = 1'b0
);
    logic [2:0] wait_q = 3'h0; // Cycles the request has stood
    // Core retires a few more instructions before it halts
    always @(posedge clk) begin
        wait_q <= break_req ? (wait_q == 3'h7 ? wait_q : wait_q + 3'h1) : 3'h0;
        stop_ack <= break_req && wait_q >= 3'h3;
    end
    // One bus cycle; type code picks fetch, exec or DMA
    task cyc(input logic [31:0] a, d, input logic [1:0] s, t);
        @(posedge clk);
        bus_valid <= 1'b1;
        bus_addr <= a;
        bus_data <= d;
        bus_size <= s;
        bus_type <= t;
        bus_rd <= 1'b1;
        @(posedge clk);
        // Inverse after release so stale lines never match by luck
        bus_valid <= 1'b0;
        bus_addr <= ~a;
        bus_data <= ~d;
        bus_rd <= 1'b0;
    endtask
endmodule

// File: tb/bus_break_comparator_tb_top.sv
// Self-checking bench for the bus break comparator
`timescale 1ns/1ps
module bus_break_comparator_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_we = 1'b0, cfg_cancel = 1'b0, cfg_all = 1'b0, seq_en = 1'b0;
    logic [4:0] cfg_chan = 5'h00;
    logic [2:0] cfg_field = 3'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [23:0] trace_claim = 24'h000020; // Channel 5 held by trace
    logic [1:0] seq_depth = 2'h0;
    logic [7:0] irq_pin = 8'h00;
    logic bus_valid, bus_rd, stop_ack, break_req, cfg_done, cfg_refused;
    logic [31:0] bus_addr, bus_data, a, d, r;
    logic [1:0] bus_size, bus_type, seq_level, s, t;
    logic [27:0] chan_hit, chan_valid;
    logic [31:0] ma [28], mm [28], md [28]; // Model copy of armed settings
    logic [15:0] mc [28];
    logic [31:0] rs = 32'h13; // Xorshift state
    int fail_count = 0, n_checks = 0, i;
    always #20 clk = ~clk;
    bbc_top dut (.clk, .nrst, .cfg_we, .cfg_chan, .cfg_field, .cfg_wdata, .cfg_cancel, .cfg_all,
        .trace_claim, .seq_en, .seq_depth, .bus_valid, .bus_addr, .bus_data, .bus_rd, .bus_size,
        .bus_type, .irq_pin, .nmi_pin(irq_pin[7]), .probe_pin(irq_pin[3:0]), .stop_ack, .break_req, .chan_hit,
        .chan_valid, .seq_level, .cfg_done, .cfg_refused);
    bbc_bus_model bus (.clk, .break_req, .bus_valid, .bus_addr, .bus_data, .bus_rd, .bus_size,
        .bus_type, .stop_ack);
    function logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // Expected group hit; lanes are replicated, so the lane choice is moot
    function logic ex(int c, logic [31:0] a, d, logic [1:0] s, t);
        logic [15:0] k;
        k = mc[c];
        ex = 1'b1;
        if (k[0] && ((a ^ ma[c]) & ~mm[c]) != 32'h0) ex = 1'b0;
        if (k[1] && (t == 2'h0 || s != k[3:2])) ex = 1'b0;
        if (k[1] && k[3:2] == 2'h0 && d[7:0] != md[c][7:0]) ex = 1'b0;
        if (k[1] && k[3:2] == 2'h1 && d[15:0] != md[c][15:0]) ex = 1'b0;
        if (k[1] && (!k[0] || mm[c] != 32'h0) && a[0]) ex = 1'b0;
        if (k[7:6] != 2'h0 && t != k[7:6]) ex = 1'b0;
    endfunction
    task chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task cw(input logic [4:0] c, input logic [2:0] f, input logic [31:0] v);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_chan <= c;
        cfg_field <= f;
        cfg_wdata <= v;
        @(posedge clk);
        cfg_we <= 1'b0;
        #1;
    endtask
    // All fields then commit; accepted settings enter the model
    task prog(input logic [4:0] c, input logic [15:0] k, input logic [31:0] a, m, d,
        input logic [23:0] p, input logic [15:0] n, input logic e);
        cw(c, 3'h0, a);
        cw(c, 3'h1, m);
        cw(c, 3'h2, d);
        cw(c, 3'h3, 32'h0);
        cw(c, 3'h4, {16'h0, k});
        cw(c, 3'h5, {8'h0, p});
        cw(c, 3'h6, {16'h0, n});
        cw(c, 3'h7, 32'h0);
        chk("cfg_refused", e, cfg_refused);
        if (!e) begin
            ma[c] = a;
            mm[c] = m;
            md[c] = d;
            mc[c] = k;
        end
    endtask
    task cyc(input logic [31:0] a, d, input logic [1:0] s, t, input logic [4:0] c, input logic e);
        bus.cyc(a, d, s, t);
        @(posedge clk);
        #1;
        chk("chan_hit", e, chan_hit[c]);
        if (e && c < 5'h18) chk("break_req", 1'b1, break_req);
    endtask
    // On-chip hit, then the stop request one edge later
    task ocb(input logic [31:0] a, input logic [4:0] c, input logic eb);
        cyc(a, 32'h0, 2'h1, 2'h1, c, 1'b1);
        @(posedge clk);
        #1;
        chk("break_req", eb, break_req);
    endtask
    task cx(input logic [4:0] c, input logic al);
        @(posedge clk);
        cfg_cancel <= 1'b1;
        cfg_chan <= c;
        cfg_all <= al;
        @(posedge clk);
        cfg_cancel <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, well past the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        chk("chan_valid", 28'h0, chan_valid);
        nrst <= 1'b1;
        prog(5'h01, 16'h0107, 32'h101, 32'h0, 32'h1234, 24'h0, 16'h0, 1'b1);
        prog(5'h01, 16'h010B, 32'h100, 32'h0, 32'h1234, 24'h0, 16'h0, 1'b1);
        prog(5'h01, 16'h0007, 32'h100, 32'h0, 32'h1234, 24'h0, 16'h0, 1'b1);
        prog(5'h01, 16'h0101, 32'h100, 32'hF0, 32'h0, 24'h0, 16'h0, 1'b1);
        prog(5'h01, 16'h01C1, 32'h100, 32'h0, 32'h0, 24'h0, 16'h0, 1'b1);
        prog(5'h01, 16'h8101, 32'h100, 32'h0, 32'h0, 24'h0, 16'h1, 1'b1);
        prog(5'h08, 16'h8101, 32'h500, 32'h0, 32'h0, 24'h0, 16'h0, 1'b1);
        prog(5'h05, 16'h0101, 32'h100, 32'h0, 32'h0, 24'h0, 16'h0, 1'b1);
        $display("test refusals done");
        prog(5'h01, 16'h0107, 32'h100, 32'h0, 32'h1234, 24'h0, 16'h0, 1'b0);
        cyc(32'h100, {2{16'h1234}}, 2'h1, 2'h1, 5'h01, 1'b1);
        cyc(32'h100, {2{16'h1235}}, 2'h1, 2'h1, 5'h01, 1'b0);
        prog(5'h02, 16'h0103, 32'h101, 32'h0, 32'h5A, 24'h0, 16'h0, 1'b0);
        cyc(32'h101, {4{8'h5A}}, 2'h0, 2'h2, 5'h02, 1'b1);
        prog(5'h07, 16'h0003, 32'h301, 32'h0, 32'hA5, 24'h0, 16'h0, 1'b0);
        cyc(32'h301, {4{8'hA5}}, 2'h0, 2'h1, 5'h07, 1'b1);
        prog(5'h03, 16'h0111, 32'h4000, 32'hF, 32'h0, 24'h0, 16'h0, 1'b0);
        cyc(32'h4007, 32'h0, 2'h1, 2'h1, 5'h03, 1'b1);
        cyc(32'h4017, 32'h0, 2'h1, 2'h1, 5'h03, 1'b0);
        prog(5'h06, 16'h0141, 32'h200, 32'h0, 32'h0, 24'h0, 16'h0, 1'b0);
        for (i = 0; i < 3; i++) cyc(32'h200, 32'h0, 2'h1, i[1:0], 5'h06, i == 1);
        $display("test match done");
        prog(5'h00, 16'h0102, 32'h0, 32'h0, 32'h5A, 24'h0, 16'h0, 1'b0);
        for (i = 0; i < 24; i++) begin
            r = xs();
            a = {28'h0000010, r[3:0]};
            d = {4{r[4] ? 8'h5A : r[15:8]}};
            s = {1'b0, r[18]};
            t = (r[17:16] == 2'h3) ? 2'h1 : r[17:16];
            cyc(a, d, s, t, 5'h00, ex(0, a, d, s, t));
        end
        $display("test random done");
        prog(5'h04, 16'h3500, 32'h0, 32'h0, 32'h0, 24'h342154, 16'h0, 1'b0);
        irq_pin <= 8'h75;
        @(posedge clk);
        cyc(32'h900, 32'h0, 2'h1, 2'h1, 5'h04, 1'b1);
        irq_pin <= 8'h56;
        repeat (3) @(posedge clk);
        cyc(32'h900, 32'h0, 2'h1, 2'h1, 5'h04, 1'b0);
        prog(5'h08, 16'h8101, 32'h500, 32'h0, 32'h0, 24'h0, 16'h3, 1'b0);
        for (i = 0; i < 4; i++) cyc(32'h500, 32'h0, 2'h1, 2'h1, 5'h08, i == 2);
        $display("test pins and count done");
        prog(5'h18, 16'h0101, 32'h600, 32'h0, 32'h0, 24'h0, 16'h0, 1'b0);
        prog(5'h19, 16'h0101, 32'h604, 32'h0, 32'h0, 24'h0, 16'h0, 1'b0);
        repeat (8) @(posedge clk);
        ocb(32'h604, 5'h19, 1'b1);
        repeat (8) @(posedge clk);
        seq_en <= 1'b1;
        seq_depth <= 2'h1;
        ocb(32'h604, 5'h19, 1'b0);
        ocb(32'h600, 5'h18, 1'b0);
        chk("seq_level", 2'h1, seq_level);
        ocb(32'h604, 5'h19, 1'b1);
        $display("test sequence done");
        cx(5'h00, 1'b1);
        chk("chan_valid", 9'h100, chan_valid[8:0]);
        cx(5'h08, 1'b0);
        chk("chan_valid", 1'b0, chan_valid[8]);
        $display("test cancel done");
        close_out();
    end
endmodule
